// ---- src/motor_startup_config_regs.sv ----
// Startup configuration registers of the sensorless motor controller
//
// Operation
// - Threshold codes 0h-11h map 0.15625A-5A, rest reserved
// - Release bit 0 brakes, 1 tristates phases
// - Advance code selects 0/30/60/90 degrees
// - Repeat code runs detection 1-4 times, averaged above one run
// - Source bit selects dedicated or general limit
// - Ramp bit enables torque current ramp-down
// - Active braking only while enable bit set
// - During reverse drive, select bit picks forward or reverse parameters
// - Second register at 86h, resets zero
// - Limit codes 0h-Dh map 0.078125A-3.75A, rest reserved
// - First register at 84h, resets zero
`timescale 1ns/10ps
`include "motor_startup_params.svh"
module motor_startup_config_regs
   import motor_startup_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Configuration port from the serial interface
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_write,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_read,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // Operating context from the control loop
   input wire logic [22:0] general_current_limit,
   input wire logic [22:0] reverse_open_loop_limit,
   input wire logic [3:0] fwd_accel_coeff_linear,
   input wire logic [3:0] fwd_accel_coeff_quadratic,
   input wire logic [3:0] rev_accel_coeff_linear,
   input wire logic [3:0] rev_accel_coeff_quadratic,
   input wire logic reverse_drive_active,
   // Position detection settings
   output logic [22:0] position_detect_current_threshold,
   output logic position_detect_threshold_reserved,
   output logic release_brake,
   output logic release_tristate,
   output logic [6:0] position_detect_advance,
   output logic [2:0] position_detect_runs,
   output logic position_detect_average,
   // Open-loop and braking settings
   output logic [22:0] open_loop_current_limit,
   output logic open_loop_limit_reserved,
   output logic [3:0] accel_coeff_linear,
   output logic [3:0] accel_coeff_quadratic,
   output logic torque_current_rampdown_enable,
   output logic active_brake_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage and configuration port

   logic [31:0] motor_startup_config_a_reg;
   logic [31:0] motor_startup_config_a_next;
   logic [31:0] motor_startup_config_b_reg;
   logic [31:0] motor_startup_config_b_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   // Write decode; every bit is plain read/write, reserved bit included
   always_comb begin
      motor_startup_config_a_next = motor_startup_config_a_reg;
      motor_startup_config_b_next = motor_startup_config_b_reg;
      if (cfg_write) begin
         if (cfg_addr == `STARTUP_A_OFFSET) begin
            motor_startup_config_a_next = cfg_wdata;
         end
         if (cfg_addr == `STARTUP_B_OFFSET) begin
            motor_startup_config_b_next = cfg_wdata;
         end
      end
   end

   // Read decode; unmapped offsets answer zero rather than stalling
   always_comb begin
      rdata_next = rdata_reg;
      rvalid_next = cfg_read;
      if (cfg_read) begin
         unique case (cfg_addr)
            `STARTUP_A_OFFSET: rdata_next = motor_startup_config_a_reg;
            `STARTUP_B_OFFSET: rdata_next = motor_startup_config_b_reg;
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         motor_startup_config_a_reg <= `STARTUP_A_RESET;
         motor_startup_config_b_reg <= `STARTUP_B_RESET;
         rdata_reg <= 32'h00000000;
         rvalid_reg <= 1'b0;
      end else begin
         motor_startup_config_a_reg <= motor_startup_config_a_next;
         motor_startup_config_b_reg <= motor_startup_config_b_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_rvalid = rvalid_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Current tables

   current_lut_if threshold_lut ();
   current_lut_if limit_lut ();

   assign threshold_lut.code = motor_startup_config_a_reg[`PD_THR_MSB:`PD_THR_LSB];
   // limit code to current, padded to table width
   assign limit_lut.code = {1'b0, motor_startup_config_b_reg[`OL_LIMIT_MSB:`OL_LIMIT_LSB]};

   current_code_lut #(
      .TABLE(TABLE_PD_THRESHOLD)
   ) u_threshold_lut (
      .clock(clock),
      .rstn(rstn),
      .lut(threshold_lut.table_side)
   );

   current_code_lut #(
      .TABLE(TABLE_OL_LIMIT)
   ) u_limit_lut (
      .clock(clock),
      .rstn(rstn),
      .lut(limit_lut.table_side)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoded settings

   logic [22:0] threshold_reg;
   logic [22:0] threshold_next;
   logic threshold_rsv_reg;
   logic threshold_rsv_next;
   logic brake_reg;
   logic brake_next;
   logic tristate_reg;
   logic tristate_next;
   logic [6:0] advance_reg;
   logic [6:0] advance_next;
   logic [2:0] runs_reg;
   logic [2:0] runs_next;
   logic average_reg;
   logic average_next;
   logic [22:0] ol_limit_reg;
   logic [22:0] ol_limit_next;
   logic ol_rsv_reg;
   logic ol_rsv_next;
   logic [3:0] coeff_lin_reg;
   logic [3:0] coeff_lin_next;
   logic [3:0] coeff_quad_reg;
   logic [3:0] coeff_quad_next;
   logic rampdown_reg;
   logic rampdown_next;
   logic brake_en_reg;
   logic brake_en_next;
   logic [1:0] adv_code;
   logic [1:0] repeat_code;
   logic use_reverse;

   assign adv_code = motor_startup_config_a_reg[`PD_ADV_MSB:`PD_ADV_LSB];
   assign repeat_code = motor_startup_config_a_reg[`PD_REPEAT_MSB:`PD_REPEAT_LSB];
   assign use_reverse = reverse_drive_active & motor_startup_config_a_reg[`REV_SELECT_BIT];

   // Field decode; the table outputs are already one cycle behind the register
   always_comb begin
      threshold_next = threshold_lut.current_ua;
      threshold_rsv_next = threshold_lut.reserved;
      brake_next = ~motor_startup_config_a_reg[`PD_RELEASE_BIT];
      tristate_next = motor_startup_config_a_reg[`PD_RELEASE_BIT];
      advance_next = 7'(adv_code * `PD_ADV_STEP_DEG);
      runs_next = 3'(repeat_code) + 3'h1;
      average_next = (repeat_code != 2'h0);
      ol_rsv_next = 1'b0;
      if (use_reverse) begin
         ol_limit_next = reverse_open_loop_limit;
      end else if (motor_startup_config_a_reg[`OL_SRC_BIT]) begin
         ol_limit_next = general_current_limit;
      end else begin
         // dedicated field and its reserved codes
         ol_limit_next = limit_lut.current_ua;
         ol_rsv_next = limit_lut.reserved;
      end
      coeff_lin_next = use_reverse ? rev_accel_coeff_linear : fwd_accel_coeff_linear;
      coeff_quad_next = use_reverse ? rev_accel_coeff_quadratic : fwd_accel_coeff_quadratic;
      rampdown_next = motor_startup_config_a_reg[`RAMPDOWN_BIT];
      brake_en_next = motor_startup_config_a_reg[`ACTIVE_BRAKE_BIT];
   end

   // Settings registers; all but the two currents and the two coefficients come up in the zero-register state, those four come up at zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         threshold_reg <= 23'h000000;
         threshold_rsv_reg <= 1'b0;
         brake_reg <= 1'b1;
         tristate_reg <= 1'b0;
         advance_reg <= 7'h00;
         runs_reg <= 3'h1;
         average_reg <= 1'b0;
         ol_limit_reg <= 23'h000000;
         ol_rsv_reg <= 1'b0;
         coeff_lin_reg <= 4'h0;
         coeff_quad_reg <= 4'h0;
         rampdown_reg <= 1'b0;
         brake_en_reg <= 1'b0;
      end else begin
         threshold_reg <= threshold_next;
         threshold_rsv_reg <= threshold_rsv_next;
         brake_reg <= brake_next;
         tristate_reg <= tristate_next;
         advance_reg <= advance_next;
         runs_reg <= runs_next;
         average_reg <= average_next;
         ol_limit_reg <= ol_limit_next;
         ol_rsv_reg <= ol_rsv_next;
         coeff_lin_reg <= coeff_lin_next;
         coeff_quad_reg <= coeff_quad_next;
         rampdown_reg <= rampdown_next;
         brake_en_reg <= brake_en_next;
      end
   end

   assign position_detect_current_threshold = threshold_reg;
   assign position_detect_threshold_reserved = threshold_rsv_reg;
   assign release_brake = brake_reg;
   assign release_tristate = tristate_reg;
   assign position_detect_advance = advance_reg;
   assign position_detect_runs = runs_reg;
   assign position_detect_average = average_reg;
   assign open_loop_current_limit = ol_limit_reg;
   assign open_loop_limit_reserved = ol_rsv_reg;
   assign accel_coeff_linear = coeff_lin_reg;
   assign accel_coeff_quadratic = coeff_quad_reg;
   assign torque_current_rampdown_enable = rampdown_reg;
   assign active_brake_enable = brake_en_reg;

endmodule

// ---- src/motor_startup_params.svh ----
// Offsets, field positions and reset values of the startup configuration registers
`ifndef MOTOR_STARTUP_PARAMS_SVH
`define MOTOR_STARTUP_PARAMS_SVH

// Register offsets on the configuration port
`define STARTUP_A_OFFSET 8'h84
`define STARTUP_B_OFFSET 8'h86

// Reset values
`define STARTUP_A_RESET 32'h00000000
`define STARTUP_B_RESET 32'h00000000

// First register fields
`define PD_THR_MSB 13
`define PD_THR_LSB 9
`define PD_RELEASE_BIT 8
`define PD_ADV_MSB 7
`define PD_ADV_LSB 6
`define PD_REPEAT_MSB 5
`define PD_REPEAT_LSB 4
`define OL_SRC_BIT 3
`define RAMPDOWN_BIT 2
`define ACTIVE_BRAKE_BIT 1
`define REV_SELECT_BIT 0

// Second register fields
`define OL_LIMIT_MSB 30
`define OL_LIMIT_LSB 27

// Last legal codes of the two current tables
`define PD_THR_LAST_CODE 5'h11
`define OL_LIMIT_LAST_CODE 5'h0D

// Advance angle step in degrees
`define PD_ADV_STEP_DEG 7'h1E

`endif

// ---- src/motor_startup_pkg.sv ----
// Shared types of the startup configuration block
package motor_startup_pkg;

   // Currents are carried in microamps
   typedef logic [22:0] current_ua_t;

   // Which current table a decoder holds
   typedef enum logic [1:0] {
      TABLE_PD_THRESHOLD = 2'b01,
      TABLE_OL_LIMIT = 2'b10
   } table_sel_t;

   typedef logic [4:0] current_code_t;

endpackage

// ---- src/current_lut_if.sv ----
// Code in, current and reserved flag out, between the bank and its table decoders
`timescale 1ns/10ps
interface current_lut_if;
   import motor_startup_pkg::*;
   current_code_t code;
   current_ua_t current_ua;
   logic reserved;

   modport bank (output code, input current_ua, input reserved);
   modport table_side (input code, output current_ua, output reserved);
endinterface

// ---- src/current_code_lut.sv ----
// Registered lookup of a field code into a current in microamps
`timescale 1ns/10ps
`include "motor_startup_params.svh"
module current_code_lut
   import motor_startup_pkg::*;
#(
   parameter table_sel_t TABLE = TABLE_PD_THRESHOLD
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Lookup port
   current_lut_if.table_side lut
);

   current_ua_t current_reg;
   current_ua_t current_next;
   logic reserved_reg;
   logic reserved_next;

   // Table lookup; reserved codes give zero current and raise the flag
   always_comb begin
      current_next = 23'h000000;
      reserved_next = 1'b0;
      if (TABLE == TABLE_PD_THRESHOLD) begin
         unique case (lut.code)
            5'h00: current_next = 23'h02625A;
            5'h01: current_next = 23'h04C4B4;
            5'h02: current_next = 23'h072420;
            5'h03: current_next = 23'h098968;
            5'h04: current_next = 23'h0BEBC2;
            5'h05: current_next = 23'h0E4E1C;
            5'h06: current_next = 23'h1312D0;
            5'h07: current_next = 23'h17D784;
            5'h08: current_next = 23'h1C9C38;
            5'h09: current_next = 23'h22F538;
            5'h0A: current_next = 23'h2625A0;
            5'h0B: current_next = 23'h2C7EA0;
            5'h0C: current_next = 23'h2FAF08;
            5'h0D: current_next = 23'h32DB88;
            5'h0E: current_next = 23'h393870;
            5'h0F: current_next = 23'h3F9170;
            5'h10: current_next = 23'h45EE58;
            5'h11: current_next = 23'h4C4B40;
            default: reserved_next = 1'b1;
         endcase
      end else begin
         unique case (lut.code)
            5'h00: current_next = 23'h01312D;
            5'h01: current_next = 23'h02625A;
            5'h02: current_next = 23'h04C4B4;
            5'h03: current_next = 23'h098968;
            5'h04: current_next = 23'h0E4E1C;
            5'h05: current_next = 23'h1312D0;
            5'h06: current_next = 23'h17D784;
            5'h07: current_next = 23'h1C9C38;
            5'h08: current_next = 23'h2160EC;
            5'h09: current_next = 23'h2625A0;
            5'h0A: current_next = 23'h2AEA54;
            5'h0B: current_next = 23'h2FAF08;
            5'h0C: current_next = 23'h3473BC;
            5'h0D: current_next = 23'h393870;
            default: reserved_next = 1'b1;
         endcase
      end
   end

   // Output registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         current_reg <= 23'h000000;
         reserved_reg <= 1'b0;
      end else begin
         current_reg <= current_next;
         reserved_reg <= reserved_next;
      end
   end

   assign lut.current_ua = current_reg;
   assign lut.reserved = reserved_reg;

endmodule

// ---- tb/motor_startup_config_regs_chk.sv ----
// Port-level assertions for the startup configuration registers
`timescale 1ns/10ps
module motor_startup_config_regs_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Configuration port
   input wire logic [7:0] cfg_addr,
   input wire logic cfg_write,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_read,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   // Context
   input wire logic [22:0] general_current_limit,
   input wire logic [3:0] fwd_accel_coeff_linear,
   input wire logic [3:0] fwd_accel_coeff_quadratic,
   input wire logic reverse_drive_active,
   // Decoded settings
   input wire logic position_detect_threshold_reserved,
   input wire logic release_brake,
   input wire logic release_tristate,
   input wire logic [6:0] position_detect_advance,
   input wire logic [2:0] position_detect_runs,
   input wire logic position_detect_average,
   input wire logic [22:0] open_loop_current_limit,
   input wire logic [3:0] accel_coeff_linear,
   input wire logic [3:0] accel_coeff_quadratic,
   input wire logic torque_current_rampdown_enable,
   input wire logic active_brake_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Write strobe to the first register
   wire wr_a = cfg_write && (cfg_addr == 8'h84);

   property p_release;
      wr_a ##1 !wr_a |=> release_tristate == $past(cfg_wdata[8], 2)
         && release_brake == !release_tristate;
   endproperty
   a_release: assert property (p_release)
      else $error("release mode outputs wrong");
   property p_adv_runs;
      wr_a ##1 !wr_a |=> position_detect_advance == $past(cfg_wdata[7:6], 2) * 7'h1E
         && position_detect_runs == {1'b0, $past(cfg_wdata[5:4], 2)} + 3'h1
         && position_detect_average == ($past(cfg_wdata[5:4], 2) != 2'h0);
   endproperty
   a_adv_runs: assert property (p_adv_runs)
      else $error("advance or repeat decode wrong");
   property p_rampdown;
      wr_a ##1 !wr_a |=> torque_current_rampdown_enable == $past(cfg_wdata[2], 2);
   endproperty
   a_rampdown: assert property (p_rampdown)
      else $error("ramp-down enable wrong");
   property p_brake;
      wr_a ##1 !wr_a |=> active_brake_enable == $past(cfg_wdata[1], 2);
   endproperty
   a_brake: assert property (p_brake)
      else $error("active brake enable wrong");
   property p_thr_reserved;
      wr_a ##1 !wr_a [*2] |=>
         position_detect_threshold_reserved == ($past(cfg_wdata[13:9], 3) > 5'h11);
   endproperty
   a_thr_reserved: assert property (p_thr_reserved)
      else $error("threshold reserved flag wrong");
   property p_ol_general;
      (wr_a && cfg_wdata[3]) ##1 (!wr_a && !reverse_drive_active) [*2] |=>
         open_loop_current_limit == $past(general_current_limit);
   endproperty
   a_ol_general: assert property (p_ol_general)
      else $error("open-loop limit not general limit");
   property p_fwd_coeff;
      !reverse_drive_active |=> accel_coeff_linear == $past(fwd_accel_coeff_linear)
         && accel_coeff_quadratic == $past(fwd_accel_coeff_quadratic);
   endproperty
   a_fwd_coeff: assert property (p_fwd_coeff)
      else $error("forward coefficients not passed");
   property p_unmapped;
      cfg_read && cfg_addr != 8'h84 && cfg_addr != 8'h86 |=>
         cfg_rvalid && cfg_rdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule

bind motor_startup_config_regs motor_startup_config_regs_chk u_chk (.*);

// ---- tb/tb_motor_startup_config_regs.sv ----
// Random and corner-case bench for the startup configuration registers
`timescale 1ns/10ps
module tb_motor_startup_config_regs;
   import motor_startup_pkg::*;
   logic clock, rstn, cfg_write, cfg_read, cfg_rvalid, reverse_drive_active;
   logic [7:0] cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, ra, rb, v;
   logic [22:0] general_current_limit, reverse_open_loop_limit;
   logic [22:0] position_detect_current_threshold, open_loop_current_limit;
   logic [3:0] fwd_accel_coeff_linear, fwd_accel_coeff_quadratic;
   logic [3:0] rev_accel_coeff_linear, rev_accel_coeff_quadratic;
   logic [3:0] accel_coeff_linear, accel_coeff_quadratic;
   logic position_detect_threshold_reserved, release_brake, release_tristate;
   logic position_detect_average, open_loop_limit_reserved;
   logic torque_current_rampdown_enable, active_brake_enable;
   logic [6:0] position_detect_advance;
   logic [2:0] position_detect_runs;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   // Current tables in microamps
   localparam logic [22:0] THR_UA [18] = '{23'h2625A, 23'h4C4B4, 23'h72420, 23'h98968,
      23'hBEBC2, 23'hE4E1C, 23'h1312D0, 23'h17D784, 23'h1C9C38, 23'h22F538, 23'h2625A0,
      23'h2C7EA0, 23'h2FAF08, 23'h32DB88, 23'h393870, 23'h3F9170, 23'h45EE58, 23'h4C4B40};
   localparam logic [22:0] OL_UA [14] = '{23'h1312D, 23'h2625A, 23'h4C4B4, 23'h98968,
      23'hE4E1C, 23'h1312D0, 23'h17D784, 23'h1C9C38, 23'h2160EC, 23'h2625A0, 23'h2AEA54,
      23'h2FAF08, 23'h3473BC, 23'h393870};

   motor_startup_config_regs DUT (.*);

   // Clock, 40 ns period
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Hang guard, far above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles > 3000) begin
         errors++;
         finish_test();
      end
   end

   // Reserved codes decode to zero current
   function automatic logic [22:0] thr_ua(input logic [4:0] c);
      return (c > 5'h11) ? 23'h0 : THR_UA[c];
   endfunction
   function automatic logic [22:0] ol_ua(input logic [3:0] c);
      return (c > 4'hD) ? 23'h0 : OL_UA[c];
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Bus tasks are entered at a falling edge and leave at one
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_write = 1'b0;
      // Let an edge pass so a following strobe is a fresh one
      @(negedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      cfg_addr = a;
      cfg_read = 1'b1;
      @(negedge clock);
      cfg_read = 1'b0;
      chk(cfg_rvalid, 1'b1);
      chk(cfg_rdata, e);
      // Idle edge between back-to-back reads
      @(negedge clock);
   endtask

   // Fresh control-loop context; stays put until the next call
   task automatic ctx();
      general_current_limit = 23'($urandom());
      reverse_open_loop_limit = 23'($urandom());
      {fwd_accel_coeff_linear, fwd_accel_coeff_quadratic} = 8'($urandom());
      {rev_accel_coeff_linear, rev_accel_coeff_quadratic} = 8'($urandom());
      reverse_drive_active = 1'($urandom());
   endtask

   // Every decoded output against the shadow registers
   task automatic chk_dec();
      logic r;
      r = reverse_drive_active && ra[0];
      repeat (3) @(negedge clock);
      chk(release_tristate, ra[8]);
      chk(release_brake, !ra[8]);
      chk(position_detect_advance, ra[7:6] * 8'h1E);
      chk(position_detect_runs, ra[5:4] + 3'h1);
      chk(position_detect_average, ra[5:4] != 2'h0);
      chk(torque_current_rampdown_enable, ra[2]);
      chk(active_brake_enable, ra[1]);
      chk(position_detect_current_threshold, thr_ua(ra[13:9]));
      chk(position_detect_threshold_reserved, ra[13:9] > 5'h11);
      chk(open_loop_current_limit, r ? reverse_open_loop_limit : ra[3] ?
         general_current_limit : ol_ua(rb[30:27]));
      chk(open_loop_limit_reserved, !r && !ra[3] && rb[30:27] > 4'hD);
      chk(accel_coeff_linear, r ? rev_accel_coeff_linear : fwd_accel_coeff_linear);
      chk(accel_coeff_quadratic, r ? rev_accel_coeff_quadratic
         : fwd_accel_coeff_quadratic);
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'hBE50C25E));
      rstn = 1'b0;
      {cfg_addr, cfg_wdata, cfg_write, cfg_read} = '0;
      ctx();
      ra = 32'h00000000;
      rb = 32'h00000000;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      chk(release_brake, 1'b1);
      chk(position_detect_runs, 3'h1);
      chk_dec();
      rd(8'h84, 32'h00000000);
      rd(8'h86, 32'h00000000);
      // All threshold codes, other bits random
      for (int c = 0; c < 32; c++) begin
         ctx();
         ra = ($urandom() & 32'hFFFFC1FF) | (32'(c) << 9);
         wr(8'h84, ra);
         chk_dec();
         rd(8'h84, ra);
      end
      // All limit codes, both registers written back to back
      for (int c = 0; c < 16; c++) begin
         ctx();
         ra = $urandom();
         rb = ($urandom() & 32'h87FFFFFF) | (32'(c) << 27);
         cfg_addr = 8'h84;
         cfg_wdata = ra;
         cfg_write = 1'b1;
         @(negedge clock);
         wr(8'h86, rb);
         chk_dec();
         rd(8'h86, rb);
      end
      // Unmapped offset ignores writes and reads zero
      wr(8'h85, $urandom());
      rd(8'h85, 32'h00000000);
      rd(8'h84, ra);
      // Read in the write cycle returns the old word
      // random word keeps the limit field on a legal code
      v = ($urandom() & 32'h87FFFFFF) | (32'($urandom() % 14) << 27);
      cfg_addr = 8'h86;
      cfg_wdata = v;
      cfg_write = 1'b1;
      cfg_read = 1'b1;
      @(negedge clock);
      {cfg_write, cfg_read} = 2'b00;
      chk(cfg_rvalid, 1'b1);
      chk(cfg_rdata, rb);
      @(negedge clock);
      rb = v;
      rd(8'h86, rb);
      chk_dec();
      finish_test();
   end
endmodule
